// file: inc/csrb_pkg.sv
// Shared constants and carrier types for the CPU state and register banks
package csrb_pkg;

    // ------------------------------------------------------------
    // Status word layout and reset value
    // ------------------------------------------------------------
    localparam logic [7:0]  PSW_RESET  = 8'h02;
    localparam int          B_IE       = 7;
    localparam int          B_Z        = 6;
    localparam int          B_BANK_SELECT_HIGH     = 5;
    localparam int          B_AC       = 4;
    localparam int          B_BANK_SELECT_LOW     = 3;
    localparam int          B_ISP      = 1;
    localparam int          B_CY       = 0;

    // ------------------------------------------------------------
    // Data memory map
    // ------------------------------------------------------------
    localparam logic [15:0] GREG_BASE  = 16'hfee0;
    localparam logic [15:0] SFR_BASE   = 16'hff00;
    localparam logic [15:0] RAM_LO_DEF = 16'hfe00;
    localparam logic [15:0] RAM_HI     = 16'hfeff;

    // ------------------------------------------------------------
    // Bus offsets (byte addresses, low byte of haddr)
    // ------------------------------------------------------------
    localparam logic [7:0]  OFF_PSW    = 8'h00;
    localparam logic [7:0]  OFF_SP     = 8'h04;
    localparam logic [7:0]  OFF_STAT   = 8'h08;
    localparam logic [15:0] SP_RESET   = 16'h0000;

    // ------------------------------------------------------------
    // Carrier types from the execution datapath
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FL_NONE, FL_ADD, FL_SUB, FL_ROTL, FL_ROTR, FL_BIT, FL_LOGIC
    } csrb_flop_e;

    typedef struct packed {
        csrb_flop_e  flagOp;   // Which flags the operation touches
        logic [7:0]  opA;      // First operand, or logic/rotate source
        logic [7:0]  opB;      // Second operand
        logic        useCarry; // Add/subtract with carry in
        logic        bitVal;   // New accumulator bit for bit operations
    } csrb_alu_s;

    typedef struct packed {
        logic        push;     // Write to stack this cycle
        logic        pop;      // Read from stack this cycle
        logic        word;     // Two bytes instead of one
        logic        load;     // Direct load of the pointer
        logic [15:0] loadVal;
    } csrb_stk_s;

    typedef struct packed {
        logic        req;      // Maskable vectored request pending
        logic        lowPri;   // That request is low priority
        logic        nmi;      // Non-maskable request pending
        logic        take;     // Sequencer enters the service routine
        logic        ieSet;    // Enable instruction
        logic        ieClr;    // Disable instruction
        logic        restore;  // Return or pop of the status word
        logic [7:0]  restoreVal;
        logic        bankWr;   // Bank select instruction
        logic [1:0]  bankVal;
    } csrb_int_s;

    typedef struct packed {
        logic        we;
        logic        wide;     // Register pair access
        logic [2:0]  idx;
        logic [15:0] wdata;
    } csrb_reg_s;

    typedef struct packed {
        logic        en;
        logic        we;
        logic        wide;
        logic [15:0] addr;
        logic [15:0] wdata;
    } csrb_mem_s;

endpackage : csrb_pkg

// file: rtl/csrb_core.sv
// CPU status word, stack pointer, banked general registers, SFR decode
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps

module csrb_core
    import csrb_pkg::*;
#(
    parameter logic [15:0] RAM_LO = RAM_LO_DEF // Variant stack floor
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire csrb_alu_s   aluIn,
    input  wire csrb_stk_s   stkIn,
    input  wire csrb_int_s   intIn,
    input  wire csrb_reg_s   regIn,
    input  wire csrb_mem_s   memIn,
    output logic [7:0]       pswOut,
    output logic [15:0]      spOut,
    output logic [15:0]      stkAddr,
    output logic             stkFault,
    output logic             intAccept,
    output logic [15:0]      regRdata,
    output logic [15:0]      memRdata,
    output logic             gregHit,
    output logic             sfrSel,
    output logic             sfrWidthErr
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic        rstMeta_q;  // First stage, read only by second
    logic        rstn;       // Synchronised reset used by every flop except the register banks

    // Release through two flops so no flop leaves reset on a split edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstn      <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstn      <= rstMeta_q;
        end
    end

    // ------------------------------------------------------------
    // Status word flags
    // ------------------------------------------------------------
    logic        ie_q, z_q, ac_q, isp_q, cy_q;
    logic [1:0]  rbs_q;      // Current register bank
    logic [8:0]  addSum;     // Add result with carry out
    logic [8:0]  subDiff;    // Subtract result with borrow out
    logic [4:0]  addNib;     // Low nibble sum, bit 4 is carry
    logic [4:0]  subNib;     // Low nibble difference, bit 4 is borrow
    logic        cin;
    logic        busWrPsw;   // Software write to the status word
    logic [7:0]  busWdat;

    assign cin     = aluIn.useCarry & cy_q;
    assign addSum  = {1'b0, aluIn.opA} + {1'b0, aluIn.opB} + {8'h00, cin};
    assign subDiff = {1'b0, aluIn.opA} - {1'b0, aluIn.opB} - {8'h00, cin};
    assign addNib  = {1'b0, aluIn.opA[3:0]} + {1'b0, aluIn.opB[3:0]}
                   + {4'h0, cin};
    assign subNib  = {1'b0, aluIn.opA[3:0]} - {1'b0, aluIn.opB[3:0]}
                   - {4'h0, cin};

    // fixed layout, bit 2 always reads zero
    assign pswOut = {ie_q, z_q, rbs_q[1], ac_q, rbs_q[0], 1'b0, isp_q, cy_q};

    // Arithmetic flags; restore beats bus, datapath beats both
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // reset value of the arithmetic flags
            z_q  <= PSW_RESET[B_Z];
            ac_q <= PSW_RESET[B_AC];
            cy_q <= PSW_RESET[B_CY];
        end else begin
            unique case (aluIn.flagOp)
                FL_ADD: begin
                    z_q  <= (addSum[7:0] == 8'h00);
                    ac_q <= addNib[4];
                    cy_q <= addSum[8];
                end
                FL_SUB: begin
                    z_q  <= (subDiff[7:0] == 8'h00);
                    ac_q <= subNib[4];
                    cy_q <= subDiff[8];
                end
                // shift-out into carry, Z and AC untouched
                FL_ROTL: cy_q <= aluIn.opA[7];
                FL_ROTR: cy_q <= aluIn.opA[0];
                FL_BIT:  cy_q <= aluIn.bitVal;
                FL_LOGIC: z_q <= (aluIn.opA == 8'h00);
                FL_NONE: begin
                    // restore of a saved status word
                    if (intIn.restore) begin
                        z_q  <= intIn.restoreVal[B_Z];
                        ac_q <= intIn.restoreVal[B_AC];
                        cy_q <= intIn.restoreVal[B_CY];
                    end else if (busWrPsw) begin
                        z_q  <= busWdat[B_Z];
                        ac_q <= busWdat[B_AC];
                        cy_q <= busWdat[B_CY];
                    end
                end
                default: ;
            endcase
        end
    end

    // Bank select
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rbs_q <= {PSW_RESET[B_BANK_SELECT_HIGH], PSW_RESET[B_BANK_SELECT_LOW]};
        // bank select instruction loads the field
        end else if (intIn.bankWr) begin
            rbs_q <= intIn.bankVal;
        end else if (intIn.restore) begin
            rbs_q <= {intIn.restoreVal[B_BANK_SELECT_HIGH], intIn.restoreVal[B_BANK_SELECT_LOW]};
        end else if (busWrPsw) begin
            rbs_q <= {busWdat[B_BANK_SELECT_HIGH], busWdat[B_BANK_SELECT_LOW]};
        end
    end

    // ------------------------------------------------------------
    // Interrupt acceptance and control flags
    // ------------------------------------------------------------
    // disabled state lets only the non-maskable through
    // low priority needs the in-service flag set
    assign intAccept = intIn.nmi
                     | (ie_q & intIn.req & (~intIn.lowPri | isp_q));

    // Taking a request clears the enable so the handler starts masked
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ie_q  <= PSW_RESET[B_IE];
            isp_q <= PSW_RESET[B_ISP];
        end else if (intIn.take) begin
            // old word goes out on pswOut for the push
            ie_q  <= 1'b0;
            isp_q <= intIn.lowPri;
        end else if (intIn.restore) begin
            ie_q  <= intIn.restoreVal[B_IE];
            isp_q <= intIn.restoreVal[B_ISP];
        end else if (intIn.ieSet | intIn.ieClr) begin
            ie_q  <= intIn.ieSet;
        end else if (busWrPsw) begin
            ie_q  <= busWdat[B_IE];
            isp_q <= busWdat[B_ISP];
        end
    end

    // ------------------------------------------------------------
    // Stack pointer
    // ------------------------------------------------------------
    logic [15:0] sp_q;
    logic        spLoaded_q; // Cleared by reset, set by first load
    logic        faultSticky_q;
    logic        busWrSp, busClrFault;
    logic [15:0] stkStep;

    assign spOut   = sp_q;
    assign stkStep = stkIn.word ? 16'h0002 : 16'h0001;
    // push writes below the old pointer, pop reads at it
    assign stkAddr = stkIn.push ? sp_q - stkStep : sp_q;
    // any stack byte outside fast RAM is a fault
    // use before the first load is a fault too
    assign stkFault = (stkIn.push | stkIn.pop)
                    & (~spLoaded_q | (stkAddr < RAM_LO)
                       | (stkAddr + stkStep - 16'h0001 > RAM_HI));

    // Contents are not meaningful after reset, only the loaded mark is
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sp_q       <= SP_RESET;
            spLoaded_q <= 1'b0;
        end else if (stkIn.load | busWrSp) begin
            sp_q       <= stkIn.load ? stkIn.loadVal : busWdat16();
            spLoaded_q <= 1'b1;
        end else if (stkIn.push) begin
            sp_q <= sp_q - stkStep;
        end else if (stkIn.pop) begin
            sp_q <= sp_q + stkStep;
        end
    end

    // Fault mark, a new fault wins over a software clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            faultSticky_q <= 1'b0;
        end else if (stkFault) begin
            faultSticky_q <= 1'b1;
        end else if (busClrFault) begin
            faultSticky_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // General register banks and data memory decode
    // ------------------------------------------------------------
    logic [7:0]  gr_q [32];  // Bank-major: bank*8 + register
    logic [4:0]  regLo;      // Byte slot addressed by the datapath
    logic [4:0]  memLo;      // Byte slot addressed through memory

    // a pair starts at the even register of the bank
    assign regLo   = {rbs_q, regIn.idx[2:1], regIn.wide ? 1'b0 : regIn.idx[0]};
    assign gregHit = memIn.en & (memIn.addr[15:5] == GREG_BASE[15:5]);
    assign memLo   = memIn.addr[4:0];
    // top page is the SFR space
    // SFRs share the memory port with the registers
    assign sfrSel  = memIn.en & (memIn.addr[15:8] == SFR_BASE[15:8]);
    // word access only where a register allows it
    // the device relies on even word addresses and flags odd
    assign sfrWidthErr = sfrSel & memIn.wide
                       & (memIn.addr[0] | ~sfrWordOk(memIn.addr[7:0]));

    // Word-capable SFR pairs; all others take bytes and bits
    function automatic logic sfrWordOk(input logic [7:0] lo);
        sfrWordOk = (lo == 8'he0) | (lo == 8'he4) | (lo == 8'he8);
    endfunction : sfrWordOk

    function automatic logic [15:0] busWdat16();
        busWdat16 = hwdata[15:0];
    endfunction : busWdat16

    // Datapath writes win over a same-cycle memory write
    always_ff @(posedge clk) begin
        if (regIn.we) begin
            gr_q[regLo] <= regIn.wdata[7:0];
            if (regIn.wide) begin
                gr_q[regLo + 5'd1] <= regIn.wdata[15:8];
            end
        end else if (gregHit & memIn.we & ~(memIn.wide & memLo[0])) begin
            gr_q[memLo] <= memIn.wdata[7:0];
            if (memIn.wide) begin
                gr_q[memLo + 5'd1] <= memIn.wdata[15:8];
            end
        end
    end

    // Registered read ports, one cycle after the request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 16'h0000;
            memRdata <= 16'h0000;
        end else begin
            regRdata <= {regIn.wide ? gr_q[regLo + 5'd1] : 8'h00,
                         gr_q[regLo]};
            memRdata <= gregHit
                      ? {memIn.wide ? gr_q[memLo + 5'd1] : 8'h00, gr_q[memLo]}
                      : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Bus slave, zero wait states
    // ------------------------------------------------------------
    logic        dWr_q;      // Data phase of a write pending
    logic [7:0]  dOff_q;

    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign busWdat     = hwdata[7:0];
    assign busWrPsw    = dWr_q & (dOff_q == OFF_PSW);
    assign busWrSp     = dWr_q & (dOff_q == OFF_SP);
    assign busClrFault = dWr_q & (dOff_q == OFF_STAT) & hwdata[1];

    // Address phase capture; read data is prepared at this edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dWr_q  <= 1'b0;
            dOff_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            dWr_q  <= hsel & hready & htrans[1] & hwrite;
            dOff_q <= haddr[7:0];
            if (hsel & hready & htrans[1] & ~hwrite) begin
                unique case (haddr[7:0])
                    OFF_PSW:  hrdata <= {24'h000000, pswOut};
                    OFF_SP:   hrdata <= {16'h0000, sp_q};
                    OFF_STAT: hrdata <= {30'h0, faultSticky_q, spLoaded_q};
                    default:  hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [1:0]  bankValW;
    logic [7:0]  opAW;
    assign bankValW = intIn.bankVal;
    assign opAW     = aluIn.opA;

    property p_zero;
        @(posedge clk) disable iff (!rstn)
        (aluIn.flagOp == FL_ADD) |=> (z_q == ($past(addSum[7:0]) == 8'h00));
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_bank;
        @(posedge clk) disable iff (!rstn)
        intIn.bankWr |=> (rbs_q == $past(bankValW)) && (pswOut[5] == rbs_q[1]);
    endproperty
    a_bank: assert property (p_bank) else $error("bank not loaded");

    property p_aux;
        @(posedge clk) disable iff (!rstn)
        (aluIn.flagOp == FL_SUB) |=> (ac_q == $past(subNib[4]));
    endproperty
    a_aux: assert property (p_aux) else $error("aux carry wrong");

    property p_lowpri;
        @(posedge clk) disable iff (!rstn)
        (intIn.lowPri && !isp_q && !intIn.nmi) |-> !intAccept;
    endproperty
    a_lowpri: assert property (p_lowpri) else $error("low pri accepted");

    property p_rot;
        @(posedge clk) disable iff (!rstn)
        (aluIn.flagOp == FL_ROTL) |=> (cy_q == $past(opAW[7])) && $stable(z_q);
    endproperty
    a_rot: assert property (p_rot) else $error("rotate carry wrong");

    property p_push;
        @(posedge clk) disable iff (!rstn)
        (stkIn.push && !stkIn.word && !stkIn.load && !busWrSp)
            |-> (stkAddr == sp_q - 16'h0001) ##1 (sp_q == $past(stkAddr));
    endproperty
    a_push: assert property (p_push) else $error("push pointer wrong");

    property p_gie;
        @(posedge clk) disable iff (!rstn)
        (!ie_q && !intIn.nmi) |-> !intAccept;
    endproperty
    a_gie: assert property (p_gie) else $error("accepted while off");

    property p_take;
        @(posedge clk) disable iff (!rstn)
        intIn.take |=> !ie_q ##1 (!ie_q || $past(intIn.ieSet) ||
                                  $past(intIn.restore) || $past(busWrPsw));
    endproperty
    a_take: assert property (p_take) else $error("enable not cleared");

    property p_reset;
        @(posedge clk) $rose(rstn) |-> (pswOut == PSW_RESET);
    endproperty
    a_reset: assert property (p_reset) else $error("status reset wrong");

endmodule : csrb_core

// file: sim/csrb_dp_model.sv
// Execution datapath stand-in that drives the block's datapath ports
`timescale 1ns/1ps
module csrb_dp_model
    import csrb_pkg::*;
(
    input  wire logic clk,
    output csrb_alu_s aluIn,
    output csrb_stk_s stkIn,
    output csrb_int_s intIn,
    output csrb_reg_s regIn,
    output csrb_mem_s memIn
);
    // ------------------------------------------------------------
    // Request tasks
    // ------------------------------------------------------------
    // Datapath idle from time zero
    initial begin
        aluIn = '0;
        stkIn = '0;
        intIn = '0;
        regIn = '0;
        memIn = '0;
    end

    // Launch one request just after an edge; held until the next edge
    task automatic drive(input csrb_alu_s a = '0,
                         input csrb_stk_s s = '0,
                         input csrb_int_s i = '0,
                         input csrb_reg_s r = '0,
                         input csrb_mem_s m = '0);
        @(posedge clk);
        aluIn <= a;
        stkIn <= s;
        intIn <= i;
        regIn <= r;
        memIn <= m;
        #1;
    endtask : drive

    // Pulses stand one cycle only, so every field drops at the next edge
    task automatic rest();
        @(posedge clk);
        aluIn <= '0;
        stkIn <= '0;
        intIn <= '0;
        regIn <= '0;
        memIn <= '0;
        #1;
    endtask : rest
endmodule : csrb_dp_model

// file: sim/tb.sv
// Self-checking bench for the CPU state and register banks
`timescale 1ns/1ps
module tb;
    import csrb_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic hready, hreadyout, hresp, stkFault, intAccept, gregHit, sfrSel;
    logic sfrWidthErr;
    logic [7:0]  pswOut;
    logic [15:0] spOut, stkAddr, regRdata, memRdata;
    csrb_alu_s aluIn;
    csrb_stk_s stkIn;
    csrb_int_s intIn;
    csrb_reg_s regIn;
    csrb_mem_s memIn;
    int err_total = 0, num_checks = 0;
    assign hready = hreadyout; // Single slave drives the bus ready
    always #12.5 clk = ~clk;   // 40 MHz

    csrb_core u_csrb_core (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .aluIn(aluIn), .stkIn(stkIn),
        .intIn(intIn), .regIn(regIn), .memIn(memIn), .pswOut(pswOut),
        .spOut(spOut), .stkAddr(stkAddr), .stkFault(stkFault),
        .intAccept(intAccept), .regRdata(regRdata), .memRdata(memRdata),
        .gregHit(gregHit), .sfrSel(sfrSel), .sfrWidthErr(sfrWidthErr));
    csrb_dp_model u_csrb_dp_model (.clk(clk), .aluIn(aluIn),
        .stkIn(stkIn), .intIn(intIn), .regIn(regIn), .memIn(memIn));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Bounded wait for ready sampled high at an edge
    task automatic waitrdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            err_total++;
            final_report();
        end
    endtask : waitrdy

    // One single AHB word transfer; read data taken at data phase end
    task automatic ahb(input logic wr, input logic [7:0] ad,
                       input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, ad};
        hwrite <= wr;
        waitrdy();
        htrans <= 2'b00;
        hwdata <= wd;
        waitrdy();
        rd = hrdata;
        #1;
    endtask : ahb

    task automatic alu(input csrb_flop_e op, input logic [7:0] a, b,
                       input logic bv, input logic [2:0] zac);
        u_csrb_dp_model.drive(.a('{op, a, b, 1'b0, bv}));
        u_csrb_dp_model.rest();
        chk("flags", {pswOut[B_Z], pswOut[B_AC], pswOut[B_CY]}, zac);
    endtask : alu

    task automatic irq(input logic r, lp, n, exp);
        u_csrb_dp_model.drive(.i('{req:r, lowPri:lp, nmi:n, default:'0}));
        chk("accept", intAccept, exp);
        u_csrb_dp_model.rest();
    endtask : irq

    // Memory port access; decode flags checked while the request stands
    task automatic mem(input logic [15:0] ad, input logic w, we,
                       input logic [15:0] wd, input logic [2:0] dec);
        u_csrb_dp_model.drive(.m('{1'b1, we, w, ad, wd}));
        chk("decode", {gregHit, sfrSel, sfrWidthErr}, dec);
        u_csrb_dp_model.rest();
    endtask : mem

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("psw reset", pswOut, 8'h02);
        ahb(1'b0, OFF_PSW, 32'h0);
        chk("bus psw", rd, 32'h02);
        // Add and subtract flags, then ops that leave Z and AC alone
        alu(FL_ADD, 8'h0f, 8'h01, 1'b0, 3'b010);
        alu(FL_ADD, 8'hff, 8'h01, 1'b0, 3'b111);
        alu(FL_SUB, 8'h00, 8'h01, 1'b0, 3'b011);
        alu(FL_SUB, 8'h10, 8'h10, 1'b0, 3'b100);
        alu(FL_ROTL, 8'h80, 8'h00, 1'b0, 3'b101);
        alu(FL_ROTR, 8'h02, 8'h00, 1'b0, 3'b100);
        alu(FL_BIT, 8'h00, 8'h00, 1'b1, 3'b101);
        for (int b = 0; b < 4; b++) begin
            u_csrb_dp_model.drive(.i('{bankWr:1'b1, bankVal:b[1:0],
                                       default:'0}));
            u_csrb_dp_model.rest();
            chk("bank", {pswOut[B_BANK_SELECT_HIGH], pswOut[B_BANK_SELECT_LOW]}, b);
        end
        chk("zero bit", pswOut[2], 1'b0);
        // Bank 3 registers seen through the data memory window
        u_csrb_dp_model.drive(.r('{1'b1, 1'b0, 3'd1, 16'h005a}));
        u_csrb_dp_model.rest();
        mem(GREG_BASE + 16'd25, 1'b0, 1'b0, '0, 3'b100);
        chk("greg byte", memRdata[7:0], 8'h5a);
        u_csrb_dp_model.drive(.r('{1'b1, 1'b1, 3'd2, 16'hbeef}));
        u_csrb_dp_model.rest();
        mem(GREG_BASE + 16'd26, 1'b1, 1'b0, '0, 3'b100);
        chk("greg pair", memRdata, 16'hbeef);
        mem(GREG_BASE + 16'd29, 1'b0, 1'b1, 16'h0077, 3'b100);
        u_csrb_dp_model.drive(.r('{1'b0, 1'b0, 3'd5, 16'h0}));
        u_csrb_dp_model.rest();
        chk("reg read", regRdata[7:0], 8'h77);
        mem(16'hfe10, 1'b0, 1'b0, '0, 3'b000);
        mem(SFR_BASE + 16'h10, 1'b0, 1'b0, '0, 3'b010);
        // Word accesses at even addresses, allowed at a word-capable SFR and flagged at a byte-only SFR
        mem(16'hffe0, 1'b1, 1'b0, '0, 3'b010);
        mem(16'hff20, 1'b1, 1'b0, '0, 3'b011);
        // Pointer loaded before any stack use
        u_csrb_dp_model.drive(.s('{1'b0, 1'b0, 1'b0, 1'b1, 16'hfe10}));
        u_csrb_dp_model.rest();
        chk("sp load", spOut, 16'hfe10);
        u_csrb_dp_model.drive(.s('{1'b1, 1'b0, 1'b0, 1'b0, 16'h0}));
        chk("push addr", stkAddr, 16'hfe0f);
        chk("no fault", stkFault, 1'b0);
        u_csrb_dp_model.rest();
        chk("sp push", spOut, 16'hfe0f);
        u_csrb_dp_model.drive(.s('{1'b0, 1'b1, 1'b0, 1'b0, 16'h0}));
        u_csrb_dp_model.rest();
        chk("sp pop", spOut, 16'hfe10);
        u_csrb_dp_model.drive(.s('{1'b0, 1'b0, 1'b0, 1'b1, RAM_LO_DEF}));
        u_csrb_dp_model.rest();
        u_csrb_dp_model.drive(.s('{1'b1, 1'b0, 1'b0, 1'b0, 16'h0}));
        chk("floor fault", stkFault, 1'b1);
        u_csrb_dp_model.rest();
        // Interrupt acceptance against enable and in-service flags
        irq(1'b1, 1'b0, 1'b0, 1'b0);
        irq(1'b0, 1'b0, 1'b1, 1'b1);
        u_csrb_dp_model.drive(.i('{ieSet:1'b1, default:'0}));
        u_csrb_dp_model.rest();
        irq(1'b1, 1'b1, 1'b0, 1'b1);
        u_csrb_dp_model.drive(.i('{restore:1'b1, restoreVal:8'h80,
                                   default:'0}));
        u_csrb_dp_model.rest();
        chk("restore", pswOut, 8'h80);
        irq(1'b1, 1'b1, 1'b0, 1'b0);
        irq(1'b1, 1'b0, 1'b0, 1'b1);
        // Taking a low-priority request masks and marks in-service
        u_csrb_dp_model.drive(.i('{take:1'b1, lowPri:1'b1, default:'0}));
        u_csrb_dp_model.rest();
        chk("take", pswOut, 8'h02);
        // Register bus writes, read back and an unmapped place
        ahb(1'b1, OFF_PSW, 32'h45);
        chk("bus wr psw", pswOut, 8'h41);
        ahb(1'b1, OFF_SP, 32'hfe80);
        ahb(1'b0, OFF_SP, 32'h0);
        chk("bus sp", rd, 32'hfe80);
        ahb(1'b1, 8'h0c, 32'hffff);
        ahb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", rd, 32'h0);
        // Status: pointer loaded and sticky floor fault, then cleared
        ahb(1'b0, OFF_STAT, 32'h0);
        chk("stat", rd, 32'h3);
        ahb(1'b1, OFF_STAT, 32'h2);
        ahb(1'b0, OFF_STAT, 32'h0);
        chk("stat clr", rd, 32'h1);
        chk("hready", hreadyout, 1'b1);
        chk("hresp", hresp, 1'b0);
        final_report();
    end
endmodule : tb
